// File: common/fpsc_pkg.sv
package fpsc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Link opcodes.
    localparam logic [7:0] OP_WAKE_SIG = 8'hab;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_BOOST = 8'ha3;
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
    localparam logic [7:0] OP_CHIP_WIPE = 8'hc7;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    // Signature value is arbitrary.
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5a;
    localparam logic [7:0] STATUS_DELIVERED = 8'h00;
    localparam logic [7:0] ARRAY_ERASED = 8'hff;
    // Frame layout in rising clock edges counted from chip select low.
    localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
    localparam logic [5:0] SIG_FIRST_BIT = 6'h20;
    localparam logic [5:0] SIG_END_BIT = 6'h28;
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    // Times and derived cycle counts.
    localparam int WAKE_DELAY_SHORT_NS = 1000;
    localparam int WAKE_DELAY_FULL_NS = 2000;
    localparam int SELECT_WAIT_US = 10;
    localparam int WRITE_HOLD_OFF_MS = 3;
    localparam int WAKE_SHORT_CYC = (WAKE_DELAY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_FULL_CYC = (WAKE_DELAY_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_WAIT_CYC = (SELECT_WAIT_US * 1000) / CLK_PERIOD_NS;
    localparam int WRITE_HOLD_OFF_CYC = (WRITE_HOLD_OFF_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 8;
    localparam int CS_GAP_CYC = WAKE_FULL_CYC;
    // Host register map.
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CMD_DUMMY_POS = 8;
    localparam int CMD_READ_POS = 10;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_WR_OK_POS = 1;
    localparam int STAT_REFUSED_POS = 2;
    localparam int STAT_RX_POS = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_OPCODE = 3'h0,
        MODE_WAKE = 3'h1,
        MODE_BOOST = 3'h2,
        MODE_SLEEP_ARM = 3'h3,
        MODE_IGNORE = 3'h4
    } fpsc_mode_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LOW = 3'h1,
        H_HIGH = 3'h2,
        H_END = 3'h3,
        H_GAP = 3'h4
    } fpsc_hstate_t;
endpackage : fpsc_pkg

// File: common/fpsc_link_if.sv
`timescale 1ns/1ns
interface fpsc_link_if;
    logic csN;
    logic sclk;
    logic serialIn;
    logic serialOut;
    logic serialOutEnN;
    logic serialOutLine;

    // Pull-up keeps the data-out wire high while the flash end leaves it.
    assign serialOutLine = serialOutEnN ? 1'b1 : serialOut;

    modport flash (input csN, input sclk, input serialIn, output serialOut, output serialOutEnN);
    modport host (output csN, output sclk, output serialIn, input serialOutLine);
endinterface : fpsc_link_if

// File: core/fpsc_flash_end.sv
`timescale 1ns/1ns
// Overview of operation
// - Deep sleep ignores all but wake command.
// - Wake command returns signature outside deep sleep.
// - Wake command ignored during internal write cycle.
// - Opcode then three dummy bytes, sampled rising.
// - Signature bits change on falling clock edges.
// - Signature repeats while clocking continues.
// - Host reads whole signature before deselecting.
// - Not sleeping: standby immediately on deselect.
// - From sleep, full read waits long delay.
// - Early deselect still wakes, after short delay.
// - Boost opcode plus three dummy bytes enters boost.
// - Wake, latch-set or sleep opcodes leave boost.
// - Power-on reset holds logic, no instruction answered.
// - Write-type commands ignored during hold-off time.
// - Host waits select time; reads allowed early.
// - Host sends writes after both waits end.
// - Powers up in standby, write latch cleared.
// - Delivered state: status zero, array erased.
// - Sleep only by command ending after bit eight.
// - Sleep command rejected during write cycle.
module fpsc_flash_end
    import fpsc_pkg::*;
#(
    parameter int HOLD_OFF_CYCLES = WRITE_HOLD_OFF_CYC,
    parameter logic [7:0] SIGNATURE = SIGNATURE_DEFAULT
) (
    // Clock, power-on reset, enable.
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Serial link.
    fpsc_link_if.flash link,
    // Array side.
    input wire logic writeBusy,
    output logic deepSleep,
    output logic boostMode,
    output logic writeLatch,
    output logic holdOffDone,
    output logic wrCmdValid,
    output logic [7:0] wrCmdCode,
    output logic [7:0] statusBits,
    output logic [7:0] erasedByte
);
    logic csS1_reg;
    logic csS2_reg;
    logic csD_reg;
    logic sclkS1_reg;
    logic sclkS2_reg;
    logic sclkD_reg;
    logic sdiS1_reg;
    logic sdiS2_reg;
    logic [5:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic [2:0] outIdx_reg;
    logic [15:0] wakeTimer_reg;
    logic waking_reg;
    logic [19:0] holdCnt_reg;
    logic serialOut_reg;
    logic serialOutEnN_reg;
    fpsc_mode_t mode_reg;
    fpsc_mode_t modeNext;
    logic sclkRise;
    logic sclkFall;
    logic csRise;
    logic decodeHit;
    logic [7:0] opNow;
    logic isWriteOp;
    logic leaveBoost;
    logic enterSleep;

    // Link pins come from the host's clock domain.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            csS1_reg <= 1'b1;
            csS2_reg <= 1'b1;
            csD_reg <= 1'b1;
            sclkS1_reg <= 1'b0;
            sclkS2_reg <= 1'b0;
            sclkD_reg <= 1'b0;
            sdiS1_reg <= 1'b0;
            sdiS2_reg <= 1'b0;
        end else if (clkEn) begin
            csS1_reg <= link.csN;
            csS2_reg <= csS1_reg;
            csD_reg <= csS2_reg;
            sclkS1_reg <= link.sclk;
            sclkS2_reg <= sclkS1_reg;
            sclkD_reg <= sclkS2_reg;
            sdiS1_reg <= link.serialIn;
            sdiS2_reg <= sdiS1_reg;
        end
    end

    assign sclkRise = clkEn & ~csS2_reg & sclkS2_reg & ~sclkD_reg;
    assign sclkFall = clkEn & ~csS2_reg & ~sclkS2_reg & sclkD_reg;
    assign csRise = clkEn & csS2_reg & ~csD_reg;
    assign opNow = {shift_reg[6:0], sdiS2_reg};
    assign decodeHit = sclkRise && (bitCnt_reg == OPCODE_LAST_BIT);
    assign isWriteOp = (opNow == OP_WRITE_LATCH_SET) || (opNow == OP_PAGE_WRITE)
        || (opNow == OP_SECTOR_WIPE) || (opNow == OP_BLOCK_WIPE)
        || (opNow == OP_CHIP_WIPE) || (opNow == OP_STATUS_WRITE);

    always_comb begin
        modeNext = MODE_IGNORE;
        if (writeBusy) begin
            modeNext = MODE_IGNORE;
        end else if (deepSleep) begin
            modeNext = (opNow == OP_WAKE_SIG) ? MODE_WAKE : MODE_IGNORE;
        end else if (opNow == OP_WAKE_SIG) begin
            modeNext = MODE_WAKE;
        end else if (opNow == OP_BOOST) begin
            modeNext = MODE_BOOST;
        end else if (opNow == OP_DEEP_SLEEP) begin
            modeNext = MODE_SLEEP_ARM;
        end
    end

    // Bits are taken on rising link clock edges, most significant first.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCnt_reg <= 6'h00;
            shift_reg <= 8'h00;
            mode_reg <= MODE_OPCODE;
        end else if (clkEn) begin
            if (csS2_reg) begin
                bitCnt_reg <= 6'h00;
                mode_reg <= MODE_OPCODE;
            end else if (sclkRise) begin
                shift_reg <= opNow;
                if (bitCnt_reg != SIG_END_BIT) begin
                    bitCnt_reg <= bitCnt_reg + 6'h01;
                end
                if (decodeHit) begin
                    mode_reg <= modeNext;
                end
            end
        end
    end

    // Sleep takes effect only if the frame ended right after the opcode.
    assign enterSleep = csRise && (mode_reg == MODE_SLEEP_ARM)
        && (bitCnt_reg == OPCODE_BITS) && !writeBusy;
    assign leaveBoost = decodeHit && !writeBusy && ((opNow == OP_WAKE_SIG)
        || (opNow == OP_WRITE_LATCH_SET) || (opNow == OP_DEEP_SLEEP));

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            deepSleep <= 1'b0;
            waking_reg <= 1'b0;
            wakeTimer_reg <= 16'h0000;
        end else if (clkEn) begin
            if (enterSleep) begin
                deepSleep <= 1'b1;
            end else if (csRise && (mode_reg == MODE_WAKE) && deepSleep) begin
                waking_reg <= 1'b1;
                if (bitCnt_reg == SIG_END_BIT) begin
                    wakeTimer_reg <= 16'(WAKE_FULL_CYC - 1);
                end else begin
                    wakeTimer_reg <= 16'(WAKE_SHORT_CYC - 1);
                end
            end else if (waking_reg) begin
                // Instructions stay ignored until the wake delay has run out.
                if (wakeTimer_reg == 16'h0000) begin
                    waking_reg <= 1'b0;
                    deepSleep <= 1'b0;
                end else begin
                    wakeTimer_reg <= wakeTimer_reg - 16'h0001;
                end
            end
        end
    end

    // Not sleeping means standby is reached as soon as the frame closes.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            boostMode <= 1'b0;
        end else if (clkEn) begin
            if (leaveBoost) begin
                boostMode <= 1'b0;
            end else if (sclkRise && (mode_reg == MODE_BOOST)
                && (bitCnt_reg == SIG_FIRST_BIT - 6'h01)) begin
                boostMode <= 1'b1;
            end
        end
    end

    // Signature output, wrapping the bit index so it repeats endlessly.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            serialOut_reg <= 1'b1;
            serialOutEnN_reg <= 1'b1;
            outIdx_reg <= 3'h7;
        end else if (clkEn) begin
            if (csS2_reg) begin
                serialOutEnN_reg <= 1'b1;
                outIdx_reg <= 3'h7;
            end else if (sclkFall && (mode_reg == MODE_WAKE)
                && (bitCnt_reg >= SIG_FIRST_BIT)) begin
                serialOut_reg <= SIGNATURE[outIdx_reg];
                serialOutEnN_reg <= 1'b0;
                outIdx_reg <= outIdx_reg - 3'h1;
            end
        end
    end

    assign link.serialOut = serialOut_reg;
    assign link.serialOutEnN = serialOutEnN_reg;

    // Power-on reset holds everything; the write hold-off counts from its release.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdCnt_reg <= 20'h00000;
            holdOffDone <= 1'b0;
        end else if (clkEn && !holdOffDone) begin
            if (holdCnt_reg == 20'(HOLD_OFF_CYCLES - 1)) begin
                holdOffDone <= 1'b1;
            end else begin
                holdCnt_reg <= holdCnt_reg + 20'h00001;
            end
        end
    end

    // Write-type opcodes are passed to the array logic only once allowed.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            writeLatch <= 1'b0;
            wrCmdValid <= 1'b0;
            wrCmdCode <= 8'h00;
        end else if (clkEn) begin
            wrCmdValid <= 1'b0;
            if (decodeHit && isWriteOp && holdOffDone && !deepSleep && !writeBusy) begin
                wrCmdValid <= 1'b1;
                wrCmdCode <= opNow;
                writeLatch <= (opNow == OP_WRITE_LATCH_SET);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusBits <= STATUS_DELIVERED;
            erasedByte <= ARRAY_ERASED;
        end else if (clkEn) begin
            statusBits <= STATUS_DELIVERED;
            erasedByte <= ARRAY_ERASED;
        end
    end
endmodule : fpsc_flash_end

// File: core/fpsc_host_end.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module fpsc_host_end
    import fpsc_pkg::*;
#(
    parameter int HOLD_OFF_CYCLES = WRITE_HOLD_OFF_CYC
) (
    // Clock, reset, enable.
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Serial link.
    fpsc_link_if.host link,
    // AXI4-Lite slave.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    fpsc_hstate_t st_reg;
    logic [3:0] awAddr_reg;
    logic awHave_reg;
    logic wHave_reg;
    logic [31:0] wData_reg;
    logic [10:0] cmd_reg;
    logic refused_reg;
    logic [7:0] rxByte_reg;
    logic [7:0] rxShift_reg;
    logic [31:0] txShift_reg;
    logic [5:0] bitsLeft_reg;
    logic [15:0] div_reg;
    logic [19:0] upCnt_reg;
    logic selReady_reg;
    logic wrReady_reg;
    logic misoS1_reg;
    logic misoS2_reg;
    logic csN_reg;
    logic sclk_reg;
    logic mosi_reg;
    logic doWrite;
    logic isWriteOp;
    logic [7:0] op;

    assign doWrite = clkEn & awHave_reg & wHave_reg & ~s_axi_bvalid;
    assign op = wData_reg[7:0];
    assign isWriteOp = (op == OP_WRITE_LATCH_SET) || (op == OP_PAGE_WRITE)
        || (op == OP_SECTOR_WIPE) || (op == OP_BLOCK_WIPE)
        || (op == OP_CHIP_WIPE) || (op == OP_STATUS_WRITE);

    // Address and data are taken in either order; the answer follows both.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awAddr_reg <= 4'h0;
            wData_reg <= 32'h00000000;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_reg <= s_axi_awaddr;
                awHave_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_reg <= s_axi_wdata;
                wHave_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
                awHave_reg <= 1'b0;
                wHave_reg <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr == REG_CMD) begin
                    s_axi_rdata <= {21'h0, cmd_reg};
                end else if (s_axi_araddr == REG_STATUS) begin
                    s_axi_rdata[STAT_BUSY_POS] <= (st_reg != H_IDLE);
                    s_axi_rdata[STAT_WR_OK_POS] <= wrReady_reg;
                    s_axi_rdata[STAT_REFUSED_POS] <= refused_reg;
                    s_axi_rdata[STAT_RX_POS +: 8] <= rxByte_reg;
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Power-up waits: selection first, then writes once the hold-off is over.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            upCnt_reg <= 20'h00000;
            selReady_reg <= 1'b0;
            wrReady_reg <= 1'b0;
        end else if (clkEn && !wrReady_reg) begin
            upCnt_reg <= upCnt_reg + 20'h00001;
            if (upCnt_reg == 20'(SELECT_WAIT_CYC - 1)) begin
                selReady_reg <= 1'b1;
            end
            if (upCnt_reg >= 20'(HOLD_OFF_CYCLES - 1)
                && upCnt_reg >= 20'(SELECT_WAIT_CYC - 1)) begin
                wrReady_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            misoS1_reg <= 1'b1;
            misoS2_reg <= 1'b1;
        end else if (clkEn) begin
            misoS1_reg <= link.serialOutLine;
            misoS2_reg <= misoS1_reg;
        end
    end

    // Frame engine; a frame ends only after its last bit, so reads hold a full byte.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= H_IDLE;
            csN_reg <= 1'b1;
            sclk_reg <= 1'b0;
            mosi_reg <= 1'b0;
            cmd_reg <= 11'h000;
            refused_reg <= 1'b0;
            rxByte_reg <= 8'h00;
            rxShift_reg <= 8'h00;
            txShift_reg <= 32'h00000000;
            bitsLeft_reg <= 6'h00;
            div_reg <= 16'h0000;
        end else if (clkEn) begin
            if (div_reg != 16'h0000) begin
                div_reg <= div_reg - 16'h0001;
            end
            unique case (st_reg)
                H_IDLE: begin
                    if (doWrite && awAddr_reg == REG_CMD) begin
                        if (!selReady_reg || (isWriteOp && !wrReady_reg)) begin
                            refused_reg <= 1'b1;
                        end else begin
                            refused_reg <= 1'b0;
                            cmd_reg <= wData_reg[10:0];
                            csN_reg <= 1'b0;
                            mosi_reg <= op[7];
                            txShift_reg <= {op, 24'h000000};
                            bitsLeft_reg <= OPCODE_BITS
                                + {1'b0, wData_reg[CMD_DUMMY_POS +: 2], 3'h0}
                                + (wData_reg[CMD_READ_POS] ? OPCODE_BITS : 6'h00);
                            div_reg <= 16'(SCLK_HALF_CYC - 1);
                            st_reg <= H_LOW;
                        end
                    end
                end
                H_LOW: begin
                    if (div_reg == 16'h0000) begin
                        sclk_reg <= 1'b1;
                        rxShift_reg <= {rxShift_reg[6:0], misoS2_reg};
                        div_reg <= 16'(SCLK_HALF_CYC - 1);
                        st_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (div_reg == 16'h0000) begin
                        sclk_reg <= 1'b0;
                        txShift_reg <= {txShift_reg[30:0], 1'b0};
                        mosi_reg <= txShift_reg[30];
                        bitsLeft_reg <= bitsLeft_reg - 6'h01;
                        div_reg <= 16'(SCLK_HALF_CYC - 1);
                        st_reg <= (bitsLeft_reg == 6'h01) ? H_END : H_LOW;
                    end
                end
                H_END: begin
                    if (div_reg == 16'h0000) begin
                        csN_reg <= 1'b1;
                        if (cmd_reg[CMD_READ_POS]) begin
                            rxByte_reg <= rxShift_reg;
                        end
                        div_reg <= 16'(CS_GAP_CYC - 1);
                        st_reg <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (div_reg == 16'h0000) begin
                        st_reg <= H_IDLE;
                    end
                end
                default: begin
                    st_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign link.csN = csN_reg;
    assign link.sclk = sclk_reg;
    assign link.serialIn = mosi_reg;
endmodule : fpsc_host_end

// File: testbench/fpsc_link_assertions.sv
`timescale 1ns/1ns
module fpsc_link_assertions
    import fpsc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link wires.
    input wire logic csN,
    input wire logic sclk,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEnN
);
    int gapCnt;
    int upCnt;
    int rises;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Counters saturate so that a long idle spell cannot wrap them.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gapCnt <= 0;
            upCnt <= 0;
        end else begin
            gapCnt <= !csN ? 0 : (gapCnt < 4000 ? gapCnt + 1 : gapCnt);
            upCnt <= upCnt < 4000 ? upCnt + 1 : upCnt;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) rises <= 0;
        else rises <= csN ? 0 : rises + int'($rose(sclk));
    end
    a_select_wait: assert property ($fell(csN) |-> upCnt >= SELECT_WAIT_CYC)
        else $error("select before wait time");
    a_cs_gap: assert property ($fell(csN) |-> gapCnt >= CS_GAP_CYC)
        else $error("deselect gap too short");
    a_sclk_idle: assert property (csN |-> !sclk)
        else $error("clock moves outside frame");
    a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("clock high time wrong");
    a_in_hold: assert property (sclk |-> $stable(serialIn))
        else $error("data in moves while clock high");
    a_out_late: assert property (!csN && !serialOutEnN |-> rises >= 32)
        else $error("data out driven before dummy bytes end");
    a_out_falls: assert property (!serialOutEnN && !$past(serialOutEnN)
        && $changed(serialOut) |-> !sclk)
        else $error("data out changes while clock high");
    a_out_release: assert property ($rose(csN) |-> ##[1:6] serialOutEnN)
        else $error("data out not released after deselect");
endmodule : fpsc_link_assertions

// File: testbench/tb_flash_power_state_control.sv
`timescale 1ns/1ns
module tb_flash_power_state_control
    import fpsc_pkg::*;
;
    // Arbitrary signature value.
    localparam logic [7:0] SIG = 8'h3c;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic writeBusy = 1'b0;
    logic deepSleep, boostMode, writeLatch, holdOffDone, wrCmdValid;
    logic [7:0] wrCmdCode, statusBits, erasedByte;
    logic [7:0] lastWr = 8'h00;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int mSleep = 0, mBoost = 0, mLatch = 0, mLast = 0;
    logic [11:0] seq [] = '{12'h3a3, 12'h7ab, 12'h3a3, 12'h006, 12'h3a3, 12'h0b9, 12'h3a3,
        12'h002, 12'h0ab, 12'h0b9, 12'h7ab, 12'h4b9, 12'hfab, 12'h8b9, 12'h002, 12'h020,
        12'h0d8, 12'h0c7, 12'h001};
    fpsc_link_if link();
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= arst_n ? cyc + 1 : 0;
    always @(posedge ref_clk) if (wrCmdValid) lastWr <= wrCmdCode;
    fpsc_host_end #(.HOLD_OFF_CYCLES(2000)) fpsc_host_end_inst (.ref_clk, .arst_n,
        .clkEn(1'b1), .link(link), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fpsc_flash_end #(.HOLD_OFF_CYCLES(2000), .SIGNATURE(SIG)) fpsc_flash_end_inst (
        .ref_clk, .arst_n, .clkEn(1'b1), .link(link), .writeBusy, .deepSleep, .boostMode,
        .writeLatch, .holdOffDone, .wrCmdValid, .wrCmdCode, .statusBits, .erasedByte);
    fpsc_link_assertions chk_inst (.ref_clk, .arst_n, .csN(link.csN), .sclk(link.sclk),
        .serialIn(link.serialIn), .serialOut(link.serialOut),
        .serialOutEnN(link.serialOutEnN));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {v, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic cmd(input logic [11:0] e);
        logic [31:0] st;
        logic [1:0] rs;
        logic [7:0] op;
        logic [7:0] expRx;
        bit wOp, refused;
        op = e[7:0];
        wOp = op inside {8'h06, 8'h02, 8'h20, 8'hd8, 8'hc7, 8'h01};
        refused = cyc < SELECT_WAIT_CYC || (wOp && cyc < 2000);
        writeBusy <= e[11];
        wr(REG_CMD, {16'($urandom()), 5'h00, e[10:0]}, rs);
        for (int n = 0; n < 2000; n++) begin
            rd(REG_STATUS, st, rs);
            if (!st[STAT_BUSY_POS]) break;
        end
        chk(8'(st[STAT_BUSY_POS]), 8'h00);
        repeat (CS_GAP_CYC) @(posedge ref_clk);
        expRx = 8'hff;
        if (!refused && !e[11]) begin
            if (op == OP_WAKE_SIG) begin
                {mSleep, mBoost, expRx} = {32'd0, 32'd0, SIG};
            end else if (mSleep == 0) begin
                if (op == OP_BOOST && e[9:8] == 2'h3) mBoost = 1;
                if (op == OP_DEEP_SLEEP) {mBoost, mSleep} = {32'd0, int'(e[10:8] == 0)};
                if (op == OP_WRITE_LATCH_SET) mBoost = 0;
                if (wOp) {mLatch, mLast} = {int'(op == OP_WRITE_LATCH_SET), int'(op)};
            end
        end
        chk(8'(st[STAT_REFUSED_POS]), 8'(refused));
        if (e[10] && !refused) chk(st[15:8], expRx);
        chk(8'(deepSleep), 8'(mSleep));
        chk(8'(boostMode), 8'(mBoost));
        chk(8'(writeLatch), 8'(mLatch));
        chk(8'(holdOffDone), 8'(cyc >= 2000));
        if (wOp) chk(lastWr, 8'(mLast));
    endtask : cmd
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(49));
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        chk(8'({deepSleep, writeLatch}), 8'h00);
        chk(statusBits, 8'h00);
        chk(erasedByte, 8'hff);
        wr(4'h8, 32'h0, r);
        chk(8'(r), 8'(RESP_SLVERR));
        rd(4'hc, d, r);
        chk(8'(r), 8'(RESP_SLVERR));
        cmd(12'h7ab);
        repeat (1000) @(posedge ref_clk);
        cmd(12'h006);
        cmd(12'h7ab);
        foreach (seq[i]) cmd(seq[i]);
        summarize();
    end
endmodule : tb_flash_power_state_control
